// file: verilog/wdcr_pkg.sv
// Package of constants and types for the watchdog with clock reference
package wdcr_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_OSC_FREQ = 8'h51;
  localparam logic [7:0] IDX_WD_CTRL = 8'hD6;
  localparam logic [7:0] IDX_WD_DISABLE = 8'hD7;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hE0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hE1;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int FREQ_W = 7;
  localparam int TMO_W = 16;
  localparam int CNT_LSB = 16;
  localparam logic [6:0] FREQ_RESET = 7'h19;
  localparam logic [6:0] FREQ_MIN = 7'h05;
  localparam logic [6:0] FREQ_MAX = 7'h64;
  localparam logic [15:0] TMO_RESET = 16'h03E8;
  localparam logic [31:0] DISABLE_MAGIC = 32'h0D15AB1E;
  localparam logic [31:0] DISABLE_RESET = 32'h0D15AB1E;

  // Interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_EXPIRED = 0;
  localparam int IRQ_REFUSED = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int TICK_US = 1000;
  localparam int DIV_W = 17;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] timeout;
  } wdcr_ctrl_type;

  typedef struct packed {
    logic is_freq;
    logic is_ctrl;
    logic is_dis;
    logic is_stat;
    logic is_mask;
  } wdcr_sel_type;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } wdcr_bus_type;

endpackage

// file: verilog/wdcr_tick_div.sv
// Millisecond tick generator divided down from the system clock
module wdcr_tick_div #(
  parameter int DIV_W = wdcr_pkg::DIV_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic [6:0] freq_mhz_i,
  input wire logic run_i,
  input wire logic clear_i,
  // Tick out
  output logic tick_o
);

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [DIV_W-1:0] last;
  logic tick_q;
  logic tick_d;
  logic at_last;

  // ---------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------
  // One period is freq_mhz * 1000 clocks
  assign last = DIV_W'(freq_mhz_i * wdcr_pkg::TICK_US - 1);
  assign at_last = div_q >= last;
  // Frozen outside run so a pending partial millisecond is kept
  assign div_d = clear_i ? '0 : (!run_i ? div_q : (at_last ? '0 : div_q + 1'b1));
  assign tick_d = !clear_i && run_i && at_last;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule // wdcr_tick_div

// file: verilog/wdcr_top.sv
// Watchdog with protected timeout, disable word and clock reference register
//
// Summary of operation
// - Seven-bit oscillator MHz field, resets to 25
// - Frequency outside 5..100 refused with error
// - Tick timing derived from programmed frequency
// - Timeout counted in millisecond ticks, 16 bits
// - Counter advances only in full-run state
// - Complement mismatch refused, otherwise acknowledged
// - Timeout in low half, resets to 1000
// - Live counter readable in upper half
// - Each kick restarts countdown from timeout
// - Expiry resets the processor tile
// - Writing zero enables the watchdog
// - Magic word resets, stops; reset value disabled
//
// The Wishbone interface to the registers was left to the implementer.
module wdcr_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Power state
  input wire logic full_run_power_state_i,
  // Outputs to the system
  output logic tile_reset_o,
  output logic tick_ms_o,
  output logic [6:0] freq_mhz_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  wdcr_pkg::wdcr_bus_type bus_q;
  wdcr_pkg::wdcr_bus_type bus_d;
  wdcr_pkg::wdcr_sel_type hit;
  wdcr_pkg::wdcr_ctrl_type ctrl_view;
  logic [6:0] freq_q;
  logic [6:0] freq_d;
  logic [15:0] tmo_q;
  logic [15:0] tmo_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [31:0] dis_q;
  logic [31:0] dis_d;
  logic [1:0] stat_q;
  logic [1:0] stat_d;
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic bad_q;
  logic bad_d;
  logic expire_q;
  logic expire_d;
  logic req;
  logic [7:0] idx;
  logic mapped;
  logic full_sel;
  logic freq_ok;
  logic pair_ok;
  logic wr_bad;
  logic do_wr;
  logic wr_freq;
  logic wr_ctrl;
  logic wr_dis;
  logic wr_stat;
  logic wr_mask;
  logic enabled;
  logic tick;
  logic kick;
  logic run;
  logic last_tick;
  logic [1:0] events;
  logic [31:0] rd_mux;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  assign req = cyc_i && stb_i;
  assign idx = adr_i[9:2];
  assign hit.is_freq = idx == wdcr_pkg::IDX_OSC_FREQ;
  assign hit.is_ctrl = idx == wdcr_pkg::IDX_WD_CTRL;
  assign hit.is_dis = idx == wdcr_pkg::IDX_WD_DISABLE;
  assign hit.is_stat = idx == wdcr_pkg::IDX_IRQ_STATUS;
  assign hit.is_mask = idx == wdcr_pkg::IDX_IRQ_MASK;
  assign mapped = |hit;
  assign full_sel = sel_i == 4'hF;

  // ---------------------------------------------------------------
  // Write checks
  // ---------------------------------------------------------------
  // Range check on the frequency
  assign freq_ok = dat_i[31:7] == 25'h0000000 &&
                   dat_i[6:0] >= wdcr_pkg::FREQ_MIN &&
                   dat_i[6:0] <= wdcr_pkg::FREQ_MAX;
  // Timeout must arrive with its exact one's complement
  assign pair_ok = dat_i[31:16] == ~dat_i[15:0];
  // Partial-lane writes are refused: every field here needs the whole word
  assign wr_bad = we_i && (!mapped || !full_sel ||
                           (hit.is_freq && !freq_ok) ||
                           (hit.is_ctrl && !pair_ok));
  assign bad_d = (bus_q == wdcr_pkg::BUS_IDLE) ? (!mapped || wr_bad) : bad_q;

  // ---------------------------------------------------------------
  // Bus answer sequencing
  // ---------------------------------------------------------------
  // Answer one cycle after the request, hold one cycle, then idle
  always_comb begin
    bus_d = bus_q;
    unique case (bus_q)
      wdcr_pkg::BUS_IDLE: begin
        if (req) begin
          bus_d = wdcr_pkg::BUS_ANSWER;
        end
      end
      wdcr_pkg::BUS_ANSWER: begin
        bus_d = wdcr_pkg::BUS_IDLE;
      end
    endcase
  end

  assign ack_o = bus_q == wdcr_pkg::BUS_ANSWER && !bad_q;
  assign err_o = bus_q == wdcr_pkg::BUS_ANSWER && bad_q;

  // Writes take effect at the edge that sees the acknowledge
  assign do_wr = req && we_i && bus_q == wdcr_pkg::BUS_ANSWER && !bad_q;
  assign wr_freq = do_wr && hit.is_freq;
  assign wr_ctrl = do_wr && hit.is_ctrl;
  assign wr_dis = do_wr && hit.is_dis;
  assign wr_stat = do_wr && hit.is_stat;
  assign wr_mask = do_wr && hit.is_mask;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  assign ctrl_view.count = cnt_q;
  assign ctrl_view.timeout = tmo_q;

  always_comb begin
    rd_mux = 32'h00000000;
    if (hit.is_freq) begin
      rd_mux = {25'h0000000, freq_q};
    end else if (hit.is_ctrl) begin
      rd_mux = ctrl_view;
    end else if (hit.is_dis) begin
      rd_mux = dis_q;
    end else if (hit.is_stat) begin
      rd_mux = {30'h00000000, stat_q};
    end else if (hit.is_mask) begin
      rd_mux = {30'h00000000, mask_q};
    end
  end

  // Sampled when the request is first seen, shown with the answer
  assign rdata_d = (bus_q == wdcr_pkg::BUS_IDLE && req && !we_i) ? rd_mux : rdata_q;
  assign dat_o = rdata_q;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  assign freq_d = wr_freq ? dat_i[6:0] : freq_q;
  assign tmo_d = wr_ctrl ? dat_i[15:0] : tmo_q;
  // Any stored value other than the magic word counts as enabled
  assign dis_d = wr_dis ? dat_i : dis_q;
  assign enabled = dis_q != wdcr_pkg::DISABLE_MAGIC;
  assign freq_mhz_o = freq_q;

  // ---------------------------------------------------------------
  // Watchdog countdown
  // ---------------------------------------------------------------
  // A valid timeout write is a kick; so is every cycle spent in the disabled state
  assign kick = wr_ctrl || !enabled;
  assign run = enabled && full_run_power_state_i;

  wdcr_tick_div #(
    .DIV_W(wdcr_pkg::DIV_W)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .freq_mhz_i(freq_q),
    .run_i(run),
    .clear_i(kick),
    .tick_o(tick)
  );

  // Tick is gated again so a late pulse after leaving full run is dropped
  assign last_tick = tick && run && cnt_q <= 16'h0001;

  always_comb begin
    cnt_d = cnt_q;
    if (wr_ctrl) begin
      cnt_d = dat_i[15:0];
    end else if (!enabled) begin
      cnt_d = tmo_q;
    end else if (last_tick) begin
      cnt_d = tmo_q;
    end else if (tick && run) begin
      cnt_d = cnt_q - 16'h0001;
    end
  end

  // Expiry gives a one-cycle reset pulse to the processor tile
  assign expire_d = last_tick && !wr_ctrl;
  assign tile_reset_o = expire_q;
  assign tick_ms_o = tick;

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  assign events[wdcr_pkg::IRQ_EXPIRED] = expire_q;
  assign events[wdcr_pkg::IRQ_REFUSED] = err_o;
  // Set wins over a write-one-to-clear in the same cycle
  assign stat_d = events | (stat_q & ~(wr_stat ? dat_i[1:0] : 2'h0));
  assign mask_d = wr_mask ? dat_i[1:0] : mask_q;
  assign irq_o = |(stat_q & mask_q);

  // ---------------------------------------------------------------
  // Flip-flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= wdcr_pkg::BUS_IDLE;
      bad_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      bus_q <= bus_d;
      bad_q <= bad_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_q <= wdcr_pkg::FREQ_RESET;
      tmo_q <= wdcr_pkg::TMO_RESET;
      cnt_q <= wdcr_pkg::TMO_RESET;
      dis_q <= wdcr_pkg::DISABLE_RESET;
    end else begin
      freq_q <= freq_d;
      tmo_q <= tmo_d;
      cnt_q <= cnt_d;
      dis_q <= dis_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      expire_q <= 1'b0;
      stat_q <= wdcr_pkg::IRQ_RESET;
      mask_q <= wdcr_pkg::IRQ_RESET;
    end else begin
      expire_q <= expire_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

endmodule // wdcr_top

// file: dv/wdcr_monitor.sv
// Concurrent checks on the watchdog bus port and outputs
module wdcr_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic err_o,
  // Watchdog outputs
  input wire logic tile_reset_o,
  input wire logic tick_ms_o,
  input wire logic [6:0] freq_mhz_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire logic req;
  wire logic wr_freq;
  wire logic wr_ctrl;
  wire logic pair_ok;
  assign req = cyc_i && stb_i;
  assign wr_freq = we_i && sel_i == 4'hF && adr_i[9:2] == wdcr_pkg::IDX_OSC_FREQ;
  assign wr_ctrl = we_i && sel_i == 4'hF && adr_i[9:2] == wdcr_pkg::IDX_WD_CTRL;
  assign pair_ok = dat_i[31:16] == ~dat_i[15:0];
  one_answer_a: assert property (!(ack_o && err_o))
    else $error("ack and err together");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  req_answered_a: assert property ($rose(req) |=> ack_o || err_o)
    else $error("request not answered next cycle");
  freq_range_a: assert property (freq_mhz_o >= 7'h05 && freq_mhz_o <= 7'h64)
    else $error("frequency out of range");
  freq_refuse_a: assert property ($rose(req) && wr_freq
    && (dat_i < 32'h5 || dat_i > 32'h64) |=> err_o)
    else $error("bad frequency not refused");
  freq_keep_a: assert property (err_o |=> $stable(freq_mhz_o))
    else $error("refused write changed frequency");
  ctrl_refuse_a: assert property ($rose(req) && wr_ctrl && !pair_ok |=> err_o)
    else $error("bad timeout pair not refused");
  ctrl_accept_a: assert property ($rose(req) && wr_ctrl && pair_ok |=> ack_o)
    else $error("good timeout pair not acknowledged");
  expiry_pulse_a: assert property (tile_reset_o |=> !tile_reset_o)
    else $error("tile reset longer than one cycle");
  tick_gap_a: assert property (tick_ms_o |=> !tick_ms_o [*8])
    else $error("ticks too close");
endmodule // wdcr_monitor

bind wdcr_top wdcr_monitor u_monitor (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .ack_o, .err_o, .tile_reset_o, .tick_ms_o, .freq_mhz_o);

// file: dv/test_wdcr_top.sv
// Self-checking bench for the watchdog with clock reference
module test_wdcr_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic run = 1'b1;
  logic [9:0] adr = 10'h000;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  logic [31:0] d;
  logic [31:0] hold;
  logic [15:0] t;
  logic [15:0] tm = 16'h03E8;
  logic [6:0] f = 7'h19;
  logic e;
  logic [31:0] dat_o;
  logic ack_o, err_o, tile_reset_o, tick_ms_o, irq_o;
  logic [6:0] freq_mhz_o;
  logic [31:0] corner [6] = '{32'h4, 32'h5, 32'h64, 32'h65, 32'h0, 32'h105};
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  int pulses;
  int ticks;
  int k;
  integer seed = 32'hc54b68a9;

  wdcr_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .full_run_power_state_i(run), .tile_reset_o(tile_reset_o), .tick_ms_o(tick_ms_o),
    .freq_mhz_o(freq_mhz_o), .irq_o(irq_o));

  always #20 clk_i = ~clk_i;

  // Cut a hang short well beyond the longest expected run
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      fails++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic freq_ok(input logic [31:0] v);
    return v >= 32'h5 && v <= 32'h64;
  endfunction

  function automatic int expiry(input int mhz, input int ticks);
    return mhz * 1000 * ticks;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] v);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= v;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    rd = dat_o;
    e = err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic watch(input int n);
    pulses = 0;
    ticks = 0;
    repeat (n) begin
      @(posedge clk_i);
      pulses += tile_reset_o;
      ticks += tick_ms_o;
    end
  endtask

  task give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, wdcr_pkg::IDX_OSC_FREQ, 0); chk(rd, 32'h19);
    bus(1'b0, wdcr_pkg::IDX_WD_CTRL, 0); chk(rd, 32'h03E803E8);
    bus(1'b0, wdcr_pkg::IDX_WD_DISABLE, 0); chk(rd, 32'h0D15AB1E);
    bus(1'b0, 8'h20, 0); chk(e, 1'b1);
    $display("Reset values done");
    for (int n = 0; n < 24; n++) begin
      d = (n < 6) ? corner[n] : ($random(seed) & 32'h8000007F);
      bus(1'b1, wdcr_pkg::IDX_OSC_FREQ, d); chk(e, !freq_ok(d));
      if (freq_ok(d)) f = d[6:0];
      bus(1'b0, wdcr_pkg::IDX_OSC_FREQ, 0); chk(rd, f);
      chk(freq_mhz_o, f);
    end
    bus(1'b1, wdcr_pkg::IDX_OSC_FREQ, 32'h5); chk(e, 1'b0);
    $display("Frequency field done");
    for (int n = 0; n < 8; n++) begin
      t = $random(seed);
      d = n[0] ? {~t, t} : {~t ^ (16'h1 << n), t};
      bus(1'b1, wdcr_pkg::IDX_WD_CTRL, d); chk(e, !n[0]);
      if (n[0]) tm = t;
      bus(1'b0, wdcr_pkg::IDX_WD_CTRL, 0); chk(rd, {tm, tm});
    end
    $display("Timeout pairing done");
    bus(1'b1, wdcr_pkg::IDX_WD_CTRL, 32'hFFFD0002);
    bus(1'b1, wdcr_pkg::IDX_IRQ_MASK, 32'h1);
    chk(irq_o, 1'b0);
    bus(1'b1, wdcr_pkg::IDX_WD_DISABLE, 0);
    k = 0;
    while (tile_reset_o !== 1'b1 && k < 12000) begin
      @(posedge clk_i);
      k++;
    end
    chk(k >= expiry(5, 2) - 8 && k <= expiry(5, 2) + 8, 1'b1);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b1);
    bus(1'b0, wdcr_pkg::IDX_IRQ_STATUS, 0); chk(rd, 32'h3);
    bus(1'b1, wdcr_pkg::IDX_IRQ_STATUS, 32'h3);
    @(posedge clk_i);
    chk(irq_o, 1'b0);
    $display("Expiry done");
    watch(6000);
    bus(1'b1, wdcr_pkg::IDX_WD_CTRL, 32'hFFFD0002);
    watch(9000); chk(pulses, 0);
    chk(ticks, 1);
    $display("Kick done");
    @(posedge clk_i);
    run <= 1'b0;
    bus(1'b0, wdcr_pkg::IDX_WD_CTRL, 0);
    hold = rd;
    watch(12000); chk(pulses, 0);
    chk(ticks, 0);
    bus(1'b0, wdcr_pkg::IDX_WD_CTRL, 0); chk(rd, hold);
    run <= 1'b1;
    $display("Power state hold done");
    bus(1'b1, wdcr_pkg::IDX_WD_DISABLE, 32'h0D15AB1E);
    bus(1'b0, wdcr_pkg::IDX_WD_CTRL, 0); chk(rd, 32'h00020002);
    watch(11000); chk(pulses, 0);
    chk(ticks, 0);
    $display("Disable done");
    give_verdict();
  end
endmodule // test_wdcr_top
